// ---- inc/mes_pkg.sv ----
package mes_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] OFF_LOST_CARRIER = 8'h00;
   localparam logic [7:0] OFF_NO_CARRIER = 8'h04;
   localparam logic [7:0] OFF_CRC_FAIL = 8'h08;
   localparam logic [7:0] OFF_PHY_RX_ERR = 8'h0c;
   localparam logic [7:0] OFF_RUNT = 8'h10;
   localparam logic [7:0] OFF_OVERSIZE = 8'h14;
   localparam logic [7:0] OFF_ODD_BIT = 8'h18;
   localparam logic [7:0] OFF_GROUP_ADDR = 8'h1c;
   localparam logic [7:0] OFF_GAP = 8'h20;
   localparam logic [7:0] OFF_RX_LIMIT = 8'h24;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
   // Counter indices
   localparam int NUM_CNT = 8;
   localparam int CNT_LOST_CARRIER = 0;
   localparam int CNT_NO_CARRIER = 1;
   localparam int CNT_CRC_FAIL = 2;
   localparam int CNT_PHY_RX_ERR = 3;
   localparam int CNT_RUNT = 4;
   localparam int CNT_OVERSIZE = 5;
   localparam int CNT_ODD_BIT = 6;
   localparam int CNT_GROUP_ADDR = 7;
   // Reset values and field layout
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
   localparam int GAP_W = 5;
   localparam logic [4:0] GAP_RESET = 5'h13;
   localparam int GAP_BASE_BITS = 20;
   localparam int GAP_STEP_BITS = 4;
   localparam int LIMIT_W = 12;
   localparam logic [11:0] LIMIT_RESET = 12'h000;
   localparam logic [11:0] LIMIT_STD_MAX = 12'h5ee;
   localparam logic [11:0] LIMIT_STD_LEN = 12'h5ee;
   localparam logic [11:0] LIMIT_CAP_CODE = 12'h800;
   localparam logic [11:0] LIMIT_CAP_LEN = 12'h800;
   localparam logic [11:0] RUNT_LEN = 12'h040;
   // One link bit time takes BIT_CYCLES clocks; a bit shorter than a clock is
   // stretched to a whole clock, so the gap then runs long
   localparam int CLK_HZ = 10_000_000;
   localparam int BIT_NS = 10;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int BIT_CYCLES = (BIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : mes_pkg

// ---- rtl/mes_stats_gap.sv ----
// Function
// [RULE1] Count carrier lost during transmission
// [RULE2] Counters stop at all ones
// [RULE3] Any write clears that counter
// [RULE4] Count no carrier during preamble
// [RULE5] Count received frames failing CRC
// [RULE6] Count PHY receive error assertions
// [RULE7] Count received frames under 64 bytes
// [RULE8] Count frames longer than length limit
// [RULE9] Residual-bit overlength frame not counted too-long
// [RULE10] Count frames with residual bits
// [RULE11] Count multicast destination frames
// [RULE12] Gap is 20 plus 4 per code
// [RULE13] Gap code resets to 0x13
// [RULE14] Software keeps gap fixed while enabled
// [RULE15] Gap bits 31..5 read zero
// [RULE16] Counters 32 bits, zero after reset
// [RULE17] Decode 12-bit receive length limit
// [RULE18] Transmitter waits gap after each frame
// [RULE19] Clear beats simultaneous count event
`timescale 1ns/10ps
`default_nettype none
module mes_stats_gap
   import mes_pkg::*;
#(
   parameter int CNT_W = 32
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_carrier_lost,
   input wire logic tx_no_carrier_pre,
   input wire logic tx_frame_done,
   input wire logic rx_er_pin,
   input wire logic rx_frame_end,
   input wire logic [11:0] rx_frame_len,
   input wire logic rx_crc_bad,
   input wire logic rx_residual_bits,
   input wire logic rx_multicast,
   output logic tx_gap_busy,
   output logic irq
);
   import mes_pkg::*;

   initial
   begin
      if (CNT_W != 32)
         $error("Counters must be 32 bits wide");
      if (BIT_CYCLES < 1 || BIT_CYCLES > 255)
         $error("Bit-time divider out of range");
   end

   logic [CNT_W-1:0] cnt [NUM_CNT];
   logic [NUM_CNT-1:0] ev;
   logic [NUM_CNT-1:0] clr;
   logic [NUM_CNT-1:0] irq_status;
   logic [NUM_CNT-1:0] irq_mask;
   logic [GAP_W-1:0] interframe_gap_code;
   logic [LIMIT_W-1:0] rx_length_limit_setting;
   logic [LIMIT_W-1:0] eff_limit;
   logic rx_er_s1;
   logic rx_er_s2;
   logic rx_er_s3;
   logic [7:0] gap_cnt;
   logic [7:0] gap_bits;
   logic bit_en;
   logic [7:0] bit_div;
   logic wr_acc;
   logic rd_acc;
   logic [31:0] next_rdata;
   logic addr_ok;

   // Writes land in the access phase; reads are captured at the setup edge
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   // PHY error pin is asynchronous: two flops, then edge detect on the second
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_er_s1 <= 1'b0;
         rx_er_s2 <= 1'b0;
         rx_er_s3 <= 1'b0;
      end
      else
      begin
         rx_er_s1 <= rx_er_pin;
         rx_er_s2 <= rx_er_s1;
         rx_er_s3 <= rx_er_s2;
      end
   end

   // Length limit decode; codes below standard clamp up, large codes clamp down
   always_comb
   begin
      if (rx_length_limit_setting <= LIMIT_STD_MAX)
         eff_limit = LIMIT_STD_LEN; // [RULE17]
      else if (rx_length_limit_setting >= LIMIT_CAP_CODE)
         eff_limit = LIMIT_CAP_LEN; // [RULE17]
      else
         eff_limit = rx_length_limit_setting; // [RULE17]
   end

   // Event strobes, one per counter
   always_comb
   begin
      ev = '0;
      ev[CNT_LOST_CARRIER] = tx_carrier_lost; // [RULE1]
      ev[CNT_NO_CARRIER] = tx_no_carrier_pre; // [RULE4]
      ev[CNT_CRC_FAIL] = rx_frame_end && rx_crc_bad; // [RULE5]
      ev[CNT_PHY_RX_ERR] = rx_er_s2 && !rx_er_s3; // [RULE6]
      ev[CNT_RUNT] = rx_frame_end && (rx_frame_len < RUNT_LEN); // [RULE7]
      // Residual bits steal the frame from the too-long counter
      ev[CNT_OVERSIZE] = rx_frame_end && (rx_frame_len > eff_limit)
         && !rx_residual_bits; // [RULE8] [RULE9]
      ev[CNT_ODD_BIT] = rx_frame_end && rx_residual_bits; // [RULE10]
      ev[CNT_GROUP_ADDR] = rx_frame_end && rx_multicast; // [RULE11]
   end

   // Write strobes that clear each counter
   always_comb
   begin
      clr = '0;
      for (int i = 0; i < NUM_CNT; i++)
         clr[i] = wr_acc && (paddr == 8'(OFF_LOST_CARRIER + 4 * i)); // [RULE3]
   end

   // Saturating counters; a clear write outranks a same-cycle event
   generate
      for (genvar g = 0; g < NUM_CNT; g++)
      begin : g_cnt
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               cnt[g] <= CNT_RESET; // [RULE16]
            else if (clr[g])
               cnt[g] <= CNT_RESET; // [RULE3] [RULE19]
            else if (ev[g] && cnt[g] != CNT_MAX)
               cnt[g] <= cnt[g] + 32'h0000_0001; // [RULE2]
         end
      end
   endgenerate

   // Configuration registers; software must not touch the gap while enabled
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         interframe_gap_code <= GAP_RESET; // [RULE13]
         rx_length_limit_setting <= LIMIT_RESET;
         irq_mask <= '0;
      end
      else if (wr_acc)
      begin
         if (paddr == OFF_GAP)
            interframe_gap_code <= pwdata[GAP_W-1:0];
         if (paddr == OFF_RX_LIMIT)
            rx_length_limit_setting <= pwdata[LIMIT_W-1:0];
         if (paddr == OFF_IRQ_MASK)
            irq_mask <= pwdata[NUM_CNT-1:0];
      end
   end

   // Sticky event status; cleared at the setup edge where its read data is taken,
   // so no event slips between capture and clear; a new event wins over the clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq_status <= '0;
      else if (rd_acc && paddr == OFF_IRQ_STATUS)
         irq_status <= ev;
      else
         irq_status <= irq_status | ev;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // Bit-time enable from a divider, one pulse every BIT_CYCLES clocks
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         bit_div <= 8'h00;
         bit_en <= 1'b0;
      end
      else if (bit_div == 8'(BIT_CYCLES - 1))
      begin
         bit_div <= 8'h00;
         bit_en <= 1'b1;
      end
      else
      begin
         bit_div <= bit_div + 8'h01;
         bit_en <= 1'b0;
      end
   end

   // Gap length in bit times: 20 plus 4 per code step
   assign gap_bits = 8'(GAP_BASE_BITS) + 8'(GAP_STEP_BITS) * {3'h0, interframe_gap_code}; // [RULE12]

   // Interframe gap timer; busy holds the transmitter off
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         gap_cnt <= 8'h00;
         tx_gap_busy <= 1'b0;
      end
      else if (tx_frame_done)
      begin
         gap_cnt <= gap_bits; // [RULE18]
         tx_gap_busy <= 1'b1;
      end
      else if (tx_gap_busy && bit_en)
      begin
         gap_cnt <= gap_cnt - 8'h01;
         if (gap_cnt == 8'h01)
            tx_gap_busy <= 1'b0; // [RULE18]
      end
   end

   // Read mux; unmapped addresses answer with an error
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      addr_ok = 1'b1;
      if (paddr < 8'(4 * NUM_CNT) && paddr[1:0] == 2'b00)
         next_rdata = cnt[paddr[4:2]];
      else if (paddr == OFF_GAP)
         next_rdata = {27'h0, interframe_gap_code}; // [RULE15]
      else if (paddr == OFF_RX_LIMIT)
         next_rdata = {20'h0, rx_length_limit_setting};
      else if (paddr == OFF_IRQ_STATUS)
         next_rdata = {24'h0, irq_status};
      else if (paddr == OFF_IRQ_MASK)
         next_rdata = {24'h0, irq_mask};
      else
         addr_ok = 1'b0;
   end

   // No wait state: ready is high in the first cycle of the access phase
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         prdata <= rd_acc ? next_rdata : 32'h0000_0000;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   a_sat_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (cnt[CNT_RUNT] == CNT_MAX && !clr[CNT_RUNT]) |=> cnt[CNT_RUNT] == CNT_MAX) // [RULE2]
      else $error("Saturated counter moved");
   a_clear_wins: assert property (@(posedge clk) disable iff (sys_rst)
      clr[CNT_CRC_FAIL] |=> cnt[CNT_CRC_FAIL] == 32'h0) // [RULE3]
      else $error("Counter not cleared by write");
   a_lost_inc: assert property (@(posedge clk) disable iff (sys_rst)
      (ev[CNT_LOST_CARRIER] && !clr[0] && cnt[0] != CNT_MAX)
      |=> cnt[0] == $past(cnt[0]) + 1) // [RULE1]
      else $error("Lost carrier count missed");
   a_residual_only: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_frame_end && rx_residual_bits) |-> !ev[CNT_OVERSIZE]) // [RULE9]
      else $error("Residual frame counted too long");
   a_gap_read: assert property (@(posedge clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == OFF_GAP) |-> prdata[31:5] == 27'h0) // [RULE15]
      else $error("Gap reserved bits not zero");
   a_limit_std: assert property (@(posedge clk) disable iff (sys_rst)
      rx_length_limit_setting < 12'h5ef |-> eff_limit == 12'h5ee) // [RULE17]
      else $error("Length limit decode wrong");
   a_gap_len: assert property (@(posedge clk) disable iff (sys_rst)
      tx_frame_done |=> gap_cnt == 8'd20 + 8'd4 * $past(interframe_gap_code)) // [RULE12]
      else $error("Gap length wrong");
   a_gap_busy: assert property (@(posedge clk) disable iff (sys_rst)
      tx_frame_done |=> tx_gap_busy[*8]) // [RULE18]
      else $error("Gap ended too soon");
   a_runt_ev: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_frame_end && rx_frame_len < 12'd64) |-> ev[CNT_RUNT]) // [RULE7]
      else $error("Runt frame not counted");

   // Bus handshake steps
   sequence s_apb_setup;
      psel && !penable;
   endsequence
   sequence s_apb_access;
      psel && penable;
   endsequence
   // Gap steps: a finished frame, then a held-off transmitter
   sequence s_gap_start;
      tx_frame_done;
   endsequence
   sequence s_gap_hold;
      tx_gap_busy [*8];
   endsequence

   // Register bus answer
   a_ready_access: assert property (@(posedge clk) disable iff (sys_rst)
      s_apb_setup ##1 s_apb_access |-> pready)
      else $error("Ready missing in access phase");
   a_ready_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      pready |=> !pready)
      else $error("Ready held too long");
   a_err_no_data: assert property (@(posedge clk) disable iff (sys_rst)
      pslverr |-> (pready && prdata == 32'h0))
      else $error("Error answer carries data");

   // Gap timing
   a_gap_long: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
      s_gap_start |=> s_gap_hold ##8 tx_gap_busy)
      else $error("Gap shorter than minimum");
   a_gap_done: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
      $fell(tx_gap_busy) |-> gap_cnt == 8'h00)
      else $error("Gap ended early");

   // Values after reset; these watch the release itself
   a_gap_reset: assert property (@(posedge clk) // [RULE13]
      $fell(sys_rst) |-> interframe_gap_code == 5'h13)
      else $error("Gap code wrong after reset");
   a_cnt_reset: assert property (@(posedge clk) // [RULE16]
      $fell(sys_rst) |-> cnt[CNT_GROUP_ADDR] == 32'h0)
      else $error("Counter not zero after reset");

   // Event decode
   a_nocar_inc: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
      (ev[CNT_NO_CARRIER] && !clr[CNT_NO_CARRIER] && cnt[CNT_NO_CARRIER] != CNT_MAX)
      |=> cnt[CNT_NO_CARRIER] == $past(cnt[CNT_NO_CARRIER]) + 32'h1)
      else $error("No carrier count missed");
   a_crc_ev: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      (rx_frame_end && rx_crc_bad) |-> ev[CNT_CRC_FAIL])
      else $error("CRC failure not counted");
   a_phy_err_edge: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
      $rose(rx_er_s2) |-> ev[CNT_PHY_RX_ERR])
      else $error("PHY error edge not counted");
   a_phy_err_once: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
      ev[CNT_PHY_RX_ERR] |=> !ev[CNT_PHY_RX_ERR])
      else $error("PHY error counted twice");
   a_runt_none: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
      (rx_frame_end && rx_frame_len >= 12'd64) |-> !ev[CNT_RUNT])
      else $error("Full frame counted as runt");
   a_oversize_ev: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
      (rx_frame_end && !rx_residual_bits && rx_frame_len > 12'h800) |-> ev[CNT_OVERSIZE])
      else $error("Long frame not counted");
   a_odd_ev: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
      (rx_frame_end && rx_residual_bits) |-> ev[CNT_ODD_BIT])
      else $error("Residual frame not counted");
   a_group_ev: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      (rx_frame_end && rx_multicast) |-> ev[CNT_GROUP_ADDR])
      else $error("Multicast frame not counted");

   // Length limit decode
   a_limit_cap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
      rx_length_limit_setting >= 12'h800 |-> eff_limit == 12'h800)
      else $error("Length limit cap wrong");
   a_limit_own: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
      (rx_length_limit_setting > 12'h5ee && rx_length_limit_setting < 12'h800)
      |-> eff_limit == rx_length_limit_setting)
      else $error("Length limit not taken as is");

   // Interrupt path
   a_irq_high: assert property (@(posedge clk) disable iff (sys_rst)
      (|(irq_status & irq_mask)) |=> irq)
      else $error("Interrupt missing");
   a_irq_low: assert property (@(posedge clk) disable iff (sys_rst)
      !(|(irq_status & irq_mask)) |=> !irq)
      else $error("Interrupt without cause");
   a_status_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      ev[CNT_LOST_CARRIER] |=> irq_status[CNT_LOST_CARRIER])
      else $error("Event status not set");
endmodule : mes_stats_gap
`default_nettype wire

// ---- bench/mes_phy_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// PHY side of the receive path: holds its error line up for a short window
module mes_phy_model
(
   input wire logic clk,
   input wire logic err_go,
   input wire logic [3:0] err_len,
   output logic rx_er_pin
);
   logic [3:0] left = 4'h0;
   // Window counter; the line drops back low once the window has run out
   always_ff @(posedge clk)
   begin
      if (err_go)
         left <= err_len;
      else if (left != 4'h0)
         left <= left - 4'h1;
   end
   assign rx_er_pin = (left != 4'h0);
endmodule : mes_phy_model
`default_nettype wire

// ---- bench/mes_stats_gap_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module mes_stats_gap_tb;
   import mes_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_go = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, tx_gap_busy, irq, rx_er_pin, err;
   // Event strobes: lost, no carrier, tx done, rx end, crc, residual, multicast
   logic [6:0] ev = 7'h00;
   logic [11:0] rx_frame_len = 12'h100;
   int n_errors = 0, total_checks = 0;
   // Counts expected after the event scenario, in register order
   logic [31:0] exp_cnt [8] = '{32'h1, 32'h2, 32'h1, 32'h1, 32'h1, 32'h3, 32'h1, 32'h1};
   always #50 clk = ~clk;
   mes_phy_model phy (.clk(clk), .err_go(err_go), .err_len(4'h3), .rx_er_pin(rx_er_pin));
   mes_stats_gap dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_carrier_lost(ev[0]), .tx_no_carrier_pre(ev[1]),
      .tx_frame_done(ev[2]), .rx_er_pin(rx_er_pin), .rx_frame_end(ev[3]),
      .rx_frame_len(rx_frame_len), .rx_crc_bad(ev[4]), .rx_residual_bits(ev[5]),
      .rx_multicast(ev[6]), .tx_gap_busy(tx_gap_busy), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   // One APB transfer, entered just after a rising edge; leaves one idle edge later
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Strobe pulse; the extra edge keeps two pulses from landing in one time step
   task automatic pulse(input logic [6:0] m);
      ev <= m;
      @(posedge clk);
      ev <= 7'h00;
      @(posedge clk);
   endtask : pulse
   task automatic frame(input logic [11:0] len, input logic [2:0] f);
      rx_frame_len <= len;
      pulse({f, 4'h8});
   endtask : frame
   task automatic t_reset;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, CNT_RESET);
      end
      apb(1'b0, OFF_GAP, 32'h0);
      chk(rd, 32'h13);
   endtask : t_reset
   task automatic t_events;
      pulse(7'h01);
      pulse(7'h02);
      pulse(7'h02);
      frame(12'd63, 3'h0);
      frame(12'd64, 3'h1);
      frame(12'd1518, 3'h4);
      frame(12'd1519, 3'h0);
      frame(12'd1519, 3'h2);
      apb(1'b1, OFF_RX_LIMIT, 32'hfff);
      frame(12'h800, 3'h0);
      frame(12'h801, 3'h0);
      apb(1'b1, OFF_RX_LIMIT, 32'h600);
      frame(12'h600, 3'h0);
      frame(12'h601, 3'h0);
      err_go <= 1'b1;
      @(posedge clk);
      err_go <= 1'b0;
      repeat (10) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, exp_cnt[i]);
         apb(1'b1, 8'(4 * i), 32'ha5a5_a5a5);
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
   endtask : t_events
   // Clear write completes on the same edge that carries a lost-carrier strobe
   task automatic t_race;
      psel <= 1'b1;
      pwrite <= 1'b1;
      paddr <= OFF_LOST_CARRIER;
      @(posedge clk);
      penable <= 1'b1;
      ev <= 7'h01;
      @(posedge clk);
      chk({31'h0, pready}, 32'h1);
      ev <= 7'h00;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      apb(1'b0, OFF_LOST_CARRIER, 32'h0);
      chk(rd, 32'h0);
   endtask : t_race
   // Gap length in clocks; the timer steps one bit every BIT_CYCLES clocks
   task automatic t_gap(input logic [4:0] code);
      int n;
      n = 0;
      apb(1'b1, OFF_GAP, {27'h0, code});
      apb(1'b0, OFF_GAP, 32'h0);
      chk(rd, {27'h0, code});
      pulse(7'h04);
      while (tx_gap_busy === 1'b1 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      n = n - BIT_CYCLES * (GAP_BASE_BITS + GAP_STEP_BITS * int'(code));
      chk({31'h0, n >= -2 && n <= 2}, 32'h1);
   endtask : t_gap
   task automatic t_irq;
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      pulse(7'h02);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      pulse(7'h01);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      chk(rd, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_irq
   // Watchdog: the whole run needs a few hundred clocks
   initial
   begin
      #1_000_000;
      n_errors++;
      stop_test;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_events;
      t_race;
      t_gap(5'h00);
      t_gap(5'h1f);
      t_gap(5'h13);
      t_irq;
      stop_test;
   end
endmodule : mes_stats_gap_tb
`default_nettype wire
